// ===== switch_routing_config.sv
// switch configuration, identification and routing-direction registers
//
// Functional notes
// - description register reads link, local processor and device processor counts
// - config bit 31 set refuses writes to all switch control registers
// - config bit 8 set blocks writes to the PLL settings register
// - config bit 0 selects one-byte headers when set, two-byte when clear
// - node identifier bits 15:0 writable, reset zero, upper bits read zero
// - any accepted PLL settings write resets the tile after the write completes
// - low directions register holds dimensions 0..7, four bits each
// - high directions register holds dimensions 8..15, four bits each
// - packets go the direction of their most significant mismatching dimension
// - user code bits 31:18 show the one-time-programmed user code
// - user code bits 17:0 show a fixed identification value
// - device identification register is entirely read-only
`timescale 1ns/100ps
module switch_routing_config #(
  parameter logic [7:0] LINK_COUNT = 8'h04,
  parameter logic [7:0] LOCAL_PROC_COUNT = 8'h02,
  parameter logic [7:0] DEVICE_PROC_COUNT = 8'h02,
  // identification values below are arbitrary
  parameter logic [3:0] ID_VERSION = 4'h1,
  parameter logic [15:0] ID_PART = 16'h1234,
  parameter logic [10:0] ID_MAKER = 11'h055,
  parameter logic [13:0] OTP_USER_CODE = 14'h0000,
  parameter logic [17:0] METAL_ID = 18'h00000,
  parameter int TILE_RESET_LEN = switch_cfg_pkg::TILE_RESET_CYCLES
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic reqValid,
  input wire switch_cfg_pkg::reg_req_t req,
  output logic respValid,
  output switch_cfg_pkg::reg_resp_t resp,
  input wire logic routeValid,
  input wire logic [15:0] routeDest,
  output logic routeDoneValid,
  output logic routeLocal,
  output logic [3:0] routeDirection,
  output logic headerOneByte,
  output logic [15:0] nodeId,
  output logic [31:0] pllSettings,
  output logic tileReset
);

  // stored state

  logic cfgWriteLock;
  logic cfgPllLock;
  logic cfgHeaderOne;
  logic [15:0] nodeIdReg;
  logic [31:0] dirLow;
  logic [31:0] dirHigh;
  logic [31:0] pllReg;
  logic [1:0] rsvdA;
  logic [1:0] rsvdB;
  switch_cfg_pkg::pll_state_t pllState;
  logic [15:0] resetCount;

  // register read images

  wire logic [31:0] descriptionWord = {
    8'h00, LINK_COUNT, LOCAL_PROC_COUNT, DEVICE_PROC_COUNT
  };

  wire logic [31:0] deviceIdWord = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};

  wire logic [31:0] userCodeWord = {OTP_USER_CODE, METAL_ID};

  wire logic [31:0] configWord = {
    cfgWriteLock, 22'h000000, cfgPllLock, 7'h00, cfgHeaderOne
  };

  wire logic [31:0] nodeIdWord = {16'h0000, nodeIdReg};

  wire logic [31:0] rsvdAWord = {30'h00000000, rsvdA};
  wire logic [31:0] rsvdBWord = {30'h00000000, rsvdB};

  // address decode

  function automatic logic regHit(input logic [7:0] num, input logic [7:0] code);
    return num == code;
  endfunction

  wire logic hitDescription = regHit(req.num, switch_cfg_pkg::REG_DESCRIPTION);
  wire logic hitConfig = regHit(req.num, switch_cfg_pkg::REG_CONFIG);
  wire logic hitNodeId = regHit(req.num, switch_cfg_pkg::REG_NODE_ID);
  wire logic hitPll = regHit(req.num, switch_cfg_pkg::REG_PLL);
  wire logic hitDeviceId = regHit(req.num, switch_cfg_pkg::REG_DEVICE_ID);
  wire logic hitUserCode = regHit(req.num, switch_cfg_pkg::REG_USER_CODE);
  wire logic hitDirLow = regHit(req.num, switch_cfg_pkg::REG_DIR_LOW);
  wire logic hitDirHigh = regHit(req.num, switch_cfg_pkg::REG_DIR_HIGH);
  wire logic hitRsvdA = regHit(req.num, switch_cfg_pkg::REG_RSVD_A);
  wire logic hitRsvdB = regHit(req.num, switch_cfg_pkg::REG_RSVD_B);

  wire logic hitReadOnly = hitDescription | hitDeviceId | hitUserCode;
  wire logic hitWritable = hitConfig | hitNodeId | hitPll | hitDirLow | hitDirHigh
                           | hitRsvdA | hitRsvdB;
  wire logic hitMapped = hitReadOnly | hitWritable;

  // write permission

  // once the global lock is set it guards itself too, so only a reset
  // can reopen the control registers
  wire logic globalRefuse = cfgWriteLock;
  wire logic pllRefuse = hitPll & cfgPllLock;

  wire logic writeReq = reqValid & req.write;
  wire logic readReq = reqValid & ~req.write;

  wire logic writeAccept = writeReq & hitWritable & ~globalRefuse & ~pllRefuse;

  wire logic wrConfig = writeAccept & hitConfig;
  wire logic wrNodeId = writeAccept & hitNodeId;
  wire logic wrPll = writeAccept & hitPll;
  wire logic wrDirLow = writeAccept & hitDirLow;
  wire logic wrDirHigh = writeAccept & hitDirHigh;
  wire logic wrRsvdA = writeAccept & hitRsvdA;
  wire logic wrRsvdB = writeAccept & hitRsvdB;

  // read data selection

  // unmapped numbers read as zero and are answered with a failure
  logic [31:0] readData;

  always_comb begin
    readData = 32'h0000_0000;
    unique case (1'b1)
      hitDescription: readData = descriptionWord;
      hitConfig: readData = configWord;
      hitNodeId: readData = nodeIdWord;
      hitPll: readData = pllReg;
      hitDeviceId: readData = deviceIdWord;
      hitUserCode: readData = userCodeWord;
      hitDirLow: readData = dirLow;
      hitDirHigh: readData = dirHigh;
      hitRsvdA: readData = rsvdAWord;
      hitRsvdB: readData = rsvdBWord;
      default: readData = 32'h0000_0000;
    endcase
  end

  wire logic reqOk = req.write ? writeAccept : hitMapped;

  switch_cfg_pkg::reg_resp_t next_resp;

  always_comb begin
    next_resp.ok = reqOk;
    next_resp.data = (readReq & hitMapped) ? readData : 32'h0000_0000;
  end

  // configuration register

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cfgWriteLock <= switch_cfg_pkg::CONFIG_RESET[switch_cfg_pkg::CFG_LOCK_BIT];
      cfgPllLock <= switch_cfg_pkg::CONFIG_RESET[switch_cfg_pkg::CFG_PLL_LOCK_BIT];
      cfgHeaderOne <= switch_cfg_pkg::CONFIG_RESET[switch_cfg_pkg::CFG_HEADER_BIT];
    end else if (wrConfig) begin
      cfgWriteLock <= req.data[switch_cfg_pkg::CFG_LOCK_BIT];
      cfgPllLock <= req.data[switch_cfg_pkg::CFG_PLL_LOCK_BIT];
      cfgHeaderOne <= req.data[switch_cfg_pkg::CFG_HEADER_BIT];
    end
  end

  // node identifier

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      nodeIdReg <= switch_cfg_pkg::NODE_ID_RESET;
    end else if (wrNodeId) begin
      nodeIdReg <= req.data[15:0];
    end
  end

  // direction tables

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      dirLow <= switch_cfg_pkg::DIR_RESET;
    end else if (wrDirLow) begin
      dirLow <= req.data;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      dirHigh <= switch_cfg_pkg::DIR_RESET;
    end else if (wrDirHigh) begin
      dirHigh <= req.data;
    end
  end

  // spare control bits

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rsvdA <= switch_cfg_pkg::RSVD_RESET;
    end else if (wrRsvdA) begin
      rsvdA <= req.data[1:0];
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rsvdB <= switch_cfg_pkg::RSVD_RESET;
    end else if (wrRsvdB) begin
      rsvdB <= req.data[1:0];
    end
  end

  // PLL settings and tile reset sequencing

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pllReg <= switch_cfg_pkg::PLL_SETTINGS_RESET;
    end else if (wrPll) begin
      pllReg <= req.data;
    end
  end

  // the wait state lets the success answer leave before the tile goes
  // down, so the writer never sees its own answer lost to the reset
  switch_cfg_pkg::pll_state_t next_pllState;
  logic [15:0] next_resetCount;
  // counting from zero gives a pulse of exactly TILE_RESET_LEN cycles
  wire logic countDone = (resetCount == 16'(TILE_RESET_LEN - 1));

  always_comb begin
    next_pllState = pllState;
    next_resetCount = resetCount;
    unique case (pllState)
      switch_cfg_pkg::PLL_IDLE: begin
        if (wrPll) begin
          next_pllState = switch_cfg_pkg::PLL_WAIT;
        end
      end
      switch_cfg_pkg::PLL_WAIT: begin
        // a further write here restarts the wait, as it does mid-pulse
        next_resetCount = 16'h0000;
        if (!wrPll) begin
          next_pllState = switch_cfg_pkg::PLL_RESET;
        end
      end
      switch_cfg_pkg::PLL_RESET: begin
        if (wrPll) begin
          next_pllState = switch_cfg_pkg::PLL_WAIT;
        end else if (countDone) begin
          next_pllState = switch_cfg_pkg::PLL_IDLE;
        end else begin
          next_resetCount = resetCount + 16'h0001;
        end
      end
      default: begin
        next_pllState = switch_cfg_pkg::PLL_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pllState <= switch_cfg_pkg::PLL_IDLE;
    end else begin
      pllState <= next_pllState;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      resetCount <= 16'h0000;
    end else begin
      resetCount <= next_resetCount;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tileReset <= 1'b0;
    end else begin
      tileReset <= (next_pllState == switch_cfg_pkg::PLL_RESET);
    end
  end

  // message answer

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      respValid <= 1'b0;
    end else begin
      respValid <= reqValid;
    end
  end

  // resp holds the last answer, so a reader that looks late still finds it
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      resp <= '0;
    end else if (reqValid) begin
      resp <= next_resp;
    end
  end

  // routing decision

  logic lookupLocal;
  logic [3:0] lookupDir;

  route_select u_route_select (
    .destination(routeDest),
    .nodeId(nodeIdReg),
    .dirLow(dirLow),
    .dirHigh(dirHigh),
    .isLocal(lookupLocal),
    .direction(lookupDir)
  );

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      routeDoneValid <= 1'b0;
    end else begin
      routeDoneValid <= routeValid;
    end
  end

  // lookups see the tables as they stood before any write in the same cycle
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      routeLocal <= 1'b0;
      routeDirection <= 4'h0;
    end else if (routeValid) begin
      routeLocal <= lookupLocal;
      // a local delivery carries no outward direction
      routeDirection <= lookupLocal ? 4'h0 : lookupDir;
    end
  end

  // outputs to the rest of the switch

  assign headerOneByte = cfgHeaderOne;
  assign nodeId = nodeIdReg;
  assign pllSettings = pllReg;

endmodule

// ===== switch_cfg_pkg.sv
// constants, types and register map of the switch configuration block
package switch_cfg_pkg;

  // register numbers as carried in configuration messages
  localparam logic [7:0] REG_DESCRIPTION = 8'h01;
  localparam logic [7:0] REG_CONFIG = 8'h04;
  localparam logic [7:0] REG_NODE_ID = 8'h05;
  localparam logic [7:0] REG_PLL = 8'h06;
  localparam logic [7:0] REG_DEVICE_ID = 8'h09;
  localparam logic [7:0] REG_USER_CODE = 8'h0A;
  localparam logic [7:0] REG_DIR_LOW = 8'h0C;
  localparam logic [7:0] REG_DIR_HIGH = 8'h0D;
  localparam logic [7:0] REG_RSVD_A = 8'h10;
  localparam logic [7:0] REG_RSVD_B = 8'h11;

  // field positions
  localparam int CFG_LOCK_BIT = 31;
  localparam int CFG_PLL_LOCK_BIT = 8;
  localparam int CFG_HEADER_BIT = 0;
  localparam int DESC_LINKS_LSB = 16;
  localparam int DESC_LOCAL_LSB = 8;
  localparam int DESC_DEVICE_LSB = 0;
  localparam int USER_CODE_LSB = 18;
  localparam int NODE_ID_WIDTH = 16;
  localparam int DIR_WIDTH = 4;
  localparam int DIMS_PER_REG = 8;
  localparam int RSVD_WIDTH = 2;

  // values after reset
  localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
  localparam logic [15:0] NODE_ID_RESET = 16'h0000;
  localparam logic [31:0] DIR_RESET = 32'h0000_0000;
  localparam logic [31:0] PLL_SETTINGS_RESET = 32'h0000_0000;
  localparam logic [1:0] RSVD_RESET = 2'h0;

  // tile reset pulse that follows a PLL settings write
  localparam int CLOCK_PERIOD_NS = 20;
  localparam int TILE_RESET_NS = 200;
  localparam int TILE_RESET_CYCLES = (TILE_RESET_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

  typedef struct packed {
    logic write;
    logic [7:0] num;
    logic [31:0] data;
  } reg_req_t;

  typedef struct packed {
    logic ok;
    logic [31:0] data;
  } reg_resp_t;

  typedef enum logic [1:0] {
    PLL_IDLE = 2'b00,
    PLL_WAIT = 2'b01,
    PLL_RESET = 2'b10
  } pll_state_t;

endpackage

// ===== route_select.sv
// direction lookup from the most significant mismatching node identifier bit
`timescale 1ns/100ps
module route_select (
  input wire logic [15:0] destination,
  input wire logic [15:0] nodeId,
  input wire logic [31:0] dirLow,
  input wire logic [31:0] dirHigh,
  output logic isLocal,
  output logic [3:0] direction
);

  function automatic logic [3:0] msbIndex(input logic [15:0] v);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (v[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction

  wire logic [15:0] mismatch = destination ^ nodeId;
  wire logic [3:0] dimension = msbIndex(mismatch);
  wire logic [63:0] allDirs = {dirHigh, dirLow};

  assign isLocal = (mismatch == 16'h0000);
  assign direction = allDirs[{dimension, 2'b00} +: 4];

endmodule

// ===== switch_routing_config_chk.sv
// port assertions for the switch configuration block
`timescale 1ns/100ps
module switch_routing_config_chk #(
  parameter int TILE_RESET_LEN = 2
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic reqValid,
  input wire switch_cfg_pkg::reg_req_t req,
  input wire logic respValid,
  input wire switch_cfg_pkg::reg_resp_t resp,
  input wire logic routeValid,
  input wire logic [15:0] routeDest,
  input wire logic routeDoneValid,
  input wire logic routeLocal,
  input wire logic [3:0] routeDirection,
  input wire logic headerOneByte,
  input wire logic [15:0] nodeId,
  input wire logic [31:0] pllSettings,
  input wire logic tileReset
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  // lock state is not a port, so it is rebuilt from accepted config writes
  logic lockAll;
  logic lockPll;
  int tileLen;
  wire wr = reqValid && req.write;
  wire cfgWr = wr && !lockAll && req.num == switch_cfg_pkg::REG_CONFIG;
  wire nodeWr = wr && !lockAll && req.num == switch_cfg_pkg::REG_NODE_ID;
  wire pllWr = wr && !lockAll && !lockPll && req.num == switch_cfg_pkg::REG_PLL;
  wire roWr = wr && (req.num inside {8'h01, 8'h09, 8'h0A});
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      lockAll <= 1'b0;
      lockPll <= 1'b0;
    end else if (cfgWr) begin
      lockAll <= req.data[31];
      lockPll <= req.data[8];
    end
  end
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tileLen <= 0;
    end else begin
      tileLen <= tileReset ? tileLen + 1 : 0;
    end
  end
  a_resp_next: assert property (reqValid |=> respValid)
    else $error("no answer after request");
  a_resp_cause: assert property (respValid |-> $past(reqValid))
    else $error("answer without request");
  a_lock_refuse: assert property (wr && lockAll |=> !resp.ok && $stable(nodeId))
    else $error("locked write accepted");
  a_ro_refuse: assert property (roWr |=> respValid && !resp.ok)
    else $error("read-only write accepted");
  a_header_mode: assert property (cfgWr |=> headerOneByte == $past(req.data[0]))
    else $error("header mode not taken");
  a_node_write: assert property (nodeWr |=> resp.ok && nodeId == $past(req.data[15:0]))
    else $error("node id write lost");
  a_tile_start: assert property (pllWr |=> !tileReset ##1 tileReset)
    else $error("tile reset missing");
  a_tile_max: assert property (tileLen <= TILE_RESET_LEN)
    else $error("tile reset too long");
  a_pll_guard: assert property (!$stable(pllSettings) |-> $past(pllWr))
    else $error("pll settings changed unasked");
  a_route_local: assert property (routeValid && routeDest == nodeId
    |=> routeDoneValid && routeLocal && routeDirection == 4'h0)
    else $error("local packet not kept");
  a_route_done: assert property (routeDoneValid |-> $past(routeValid))
    else $error("route answer without lookup");
  c_pll: cover property (pllWr);
  c_lock: cover property (lockAll && wr);
  c_route: cover property (routeDoneValid && !routeLocal);
endmodule

// ===== msg_source.sv
// neighbouring switch model issuing configuration messages
`timescale 1ns/100ps
module msg_source (
  input wire logic clock,
  output logic reqValid,
  output switch_cfg_pkg::reg_req_t req,
  input wire logic respValid,
  input wire switch_cfg_pkg::reg_resp_t resp
);
  initial begin
    reqValid = 1'b0;
    req = '0;
  end
  // the word is inverted once taken so stale data cannot pass for good data
  task automatic xfer(input logic w, input logic [7:0] n, input logic [31:0] d,
    output logic seen, output switch_cfg_pkg::reg_resp_t r);
    @(negedge clock);
    reqValid = 1'b1;
    req = '{write: w, num: n, data: d};
    @(negedge clock);
    reqValid = 1'b0;
    req = '{write: ~w, num: ~n, data: ~d};
    seen = respValid;
    r = resp;
  endtask
endmodule

// ===== tb.sv
// self-checking bench for the switch configuration block
`timescale 1ns/100ps
module tb;
  // identification values are arbitrary
  localparam logic [3:0] VER = 4'h2;
  localparam logic [15:0] PART = 16'hA5C3;
  localparam logic [10:0] MAKER = 11'h1B6;
  localparam logic [13:0] UCODE = 14'h2D4B;
  localparam logic [17:0] METAL = 18'h3C0F1;
  localparam logic [31:0] DESC = 32'h0003_0204;
  logic clock, arst_n, reqValid, respValid, routeValid, routeDoneValid, routeLocal;
  switch_cfg_pkg::reg_req_t req;
  switch_cfg_pkg::reg_resp_t resp;
  logic [15:0] routeDest, nodeId;
  logic [3:0] routeDirection;
  logic headerOneByte, tileReset;
  logic [31:0] pllSettings;
  int failures = 0;
  int check_count = 0;
  int cycles = 0;
  switch_routing_config #(.LINK_COUNT(8'h03), .LOCAL_PROC_COUNT(8'h02),
    .DEVICE_PROC_COUNT(8'h04), .ID_VERSION(VER), .ID_PART(PART), .ID_MAKER(MAKER),
    .OTP_USER_CODE(UCODE), .METAL_ID(METAL), .TILE_RESET_LEN(2)) u_switch_routing_config (
    .clock(clock), .arst_n(arst_n), .reqValid(reqValid), .req(req), .respValid(respValid),
    .resp(resp), .routeValid(routeValid), .routeDest(routeDest),
    .routeDoneValid(routeDoneValid), .routeLocal(routeLocal),
    .routeDirection(routeDirection), .headerOneByte(headerOneByte), .nodeId(nodeId),
    .pllSettings(pllSettings), .tileReset(tileReset));
  msg_source u_msg_source (.clock(clock), .reqValid(reqValid), .req(req),
    .respValid(respValid), .resp(resp));
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic complete_run();
    if (failures == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic access(input logic w, input logic [7:0] n, input logic [31:0] d,
    input logic expOk, input logic [31:0] expData);
    logic seen;
    switch_cfg_pkg::reg_resp_t r;
    u_msg_source.xfer(w, n, d, seen, r);
    check("answer", {31'h0, seen}, 32'h1);
    check("ok", {31'h0, r.ok}, {31'h0, expOk});
    if (!w) check("data", r.data, expData);
  endtask
  task automatic wr(input logic [7:0] n, input logic [31:0] d, input logic ok);
    access(1'b1, n, d, ok, 32'h0);
  endtask
  task automatic rd(input logic [7:0] n, input logic [31:0] exp);
    access(1'b0, n, 32'h0, 1'b1, exp);
  endtask
  task automatic route(input logic [15:0] dest, input logic expLocal, input logic [3:0] dir);
    @(negedge clock);
    routeValid = 1'b1;
    routeDest = dest;
    @(negedge clock);
    routeValid = 1'b0;
    routeDest = ~dest;
    check("done", {31'h0, routeDoneValid}, 32'h1);
    check("local", {31'h0, routeLocal}, {31'h0, expLocal});
    check("direction", {28'h0, routeDirection}, {28'h0, dir});
  endtask
  task automatic t_reset_values();
    rd(switch_cfg_pkg::REG_DESCRIPTION, DESC);
    rd(switch_cfg_pkg::REG_CONFIG, 32'h0);
    rd(switch_cfg_pkg::REG_NODE_ID, 32'h0);
    rd(switch_cfg_pkg::REG_PLL, switch_cfg_pkg::PLL_SETTINGS_RESET);
    rd(switch_cfg_pkg::REG_DIR_LOW, 32'h0);
    rd(switch_cfg_pkg::REG_DIR_HIGH, 32'h0);
    rd(switch_cfg_pkg::REG_DEVICE_ID, {VER, PART, MAKER, 1'b1});
    rd(switch_cfg_pkg::REG_USER_CODE, {UCODE, METAL});
  endtask
  task automatic t_read_only();
    wr(switch_cfg_pkg::REG_DESCRIPTION, 32'hFFFF_FFFF, 1'b0);
    wr(switch_cfg_pkg::REG_DEVICE_ID, 32'h0, 1'b0);
    wr(switch_cfg_pkg::REG_USER_CODE, 32'hFFFF_FFFF, 1'b0);
    wr(8'h20, 32'h1, 1'b0);
    access(1'b0, 8'h20, 32'h0, 1'b0, 32'h0);
  endtask
  task automatic t_node_reserved();
    wr(switch_cfg_pkg::REG_NODE_ID, 32'hFFFF_FFFF, 1'b1);
    rd(switch_cfg_pkg::REG_NODE_ID, 32'h0000_FFFF);
    check("nodeId", {16'h0, nodeId}, 32'h0000_FFFF);
    wr(switch_cfg_pkg::REG_RSVD_A, 32'hFFFF_FFFE, 1'b1);
    rd(switch_cfg_pkg::REG_RSVD_A, 32'h2);
    wr(switch_cfg_pkg::REG_RSVD_B, 32'h0000_0001, 1'b1);
    rd(switch_cfg_pkg::REG_RSVD_B, 32'h1);
  endtask
  task automatic t_header();
    wr(switch_cfg_pkg::REG_CONFIG, 32'h1, 1'b1);
    check("header", {31'h0, headerOneByte}, 32'h1);
    wr(switch_cfg_pkg::REG_CONFIG, 32'h0, 1'b1);
    check("header", {31'h0, headerOneByte}, 32'h0);
  endtask
  task automatic t_routing();
    logic [63:0] dirs;
    dirs = 64'h0FED_CBA9_8765_4321;
    wr(switch_cfg_pkg::REG_NODE_ID, 32'h5AC3, 1'b1);
    wr(switch_cfg_pkg::REG_DIR_LOW, dirs[31:0], 1'b1);
    wr(switch_cfg_pkg::REG_DIR_HIGH, dirs[63:32], 1'b1);
    rd(switch_cfg_pkg::REG_DIR_LOW, dirs[31:0]);
    // lower bit flipped too: only the highest mismatch may decide
    for (int i = 0; i < 16; i++) begin
      route(16'h5AC3 ^ (16'h1 << i) ^ (16'h1 << i >> 1), 1'b0, dirs[4*i +: 4]);
    end
    route(16'h5AC3, 1'b1, 4'h0);
  endtask
  task automatic t_pll();
    int highs;
    highs = 0;
    wr(switch_cfg_pkg::REG_PLL, 32'h1234_5678, 1'b1);
    check("pll", pllSettings, 32'h1234_5678);
    repeat (6) begin
      @(negedge clock);
      highs += (tileReset === 1'b1);
    end
    check("tileLen", highs, 32'd2);
    // second write lands mid-pulse: the pulse must start over at full length
    wr(switch_cfg_pkg::REG_PLL, 32'h0F0F_0F0F, 1'b1);
    wr(switch_cfg_pkg::REG_PLL, 32'h1234_5678, 1'b1);
    check("tile", {31'h0, tileReset}, 32'h0);
    highs = 0;
    repeat (6) begin
      @(negedge clock);
      highs += (tileReset === 1'b1);
    end
    check("tileLen", highs, 32'd2);
    wr(switch_cfg_pkg::REG_CONFIG, 32'h100, 1'b1);
    wr(switch_cfg_pkg::REG_PLL, 32'hFFFF_FFFF, 1'b0);
    check("pll", pllSettings, 32'h1234_5678);
    check("tile", {31'h0, tileReset}, 32'h0);
  endtask
  task automatic t_lock();
    wr(switch_cfg_pkg::REG_CONFIG, 32'h8000_0000, 1'b1);
    wr(switch_cfg_pkg::REG_NODE_ID, 32'h1111, 1'b0);
    wr(switch_cfg_pkg::REG_DIR_HIGH, 32'h1111_1111, 1'b0);
    wr(switch_cfg_pkg::REG_CONFIG, 32'h0, 1'b0);
    rd(switch_cfg_pkg::REG_NODE_ID, 32'h5AC3);
    rd(switch_cfg_pkg::REG_DIR_HIGH, 32'h0FED_CBA9);
    rd(switch_cfg_pkg::REG_CONFIG, 32'h8000_0000);
    @(negedge clock);
    arst_n = 1'b0;
    repeat (2) @(negedge clock);
    check("nodeId", {16'h0, nodeId}, 32'h0);
    check("pll", pllSettings, switch_cfg_pkg::PLL_SETTINGS_RESET);
    arst_n = 1'b1;
    t_reset_values();
  endtask
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures++;
      complete_run();
    end
  end
  initial begin
    arst_n = 1'b0;
    routeValid = 1'b0;
    routeDest = 16'h0;
    repeat (2) @(negedge clock);
    arst_n = 1'b1;
    t_reset_values();
    t_read_only();
    t_reset_values();
    t_node_reserved();
    t_header();
    t_routing();
    t_pll();
    t_lock();
    complete_run();
  end
endmodule
bind switch_routing_config switch_routing_config_chk #(.TILE_RESET_LEN(TILE_RESET_LEN)) u_chk (
  .clock(clock), .arst_n(arst_n), .reqValid(reqValid), .req(req), .respValid(respValid),
  .resp(resp), .routeValid(routeValid), .routeDest(routeDest),
  .routeDoneValid(routeDoneValid), .routeLocal(routeLocal), .routeDirection(routeDirection),
  .headerOneByte(headerOneByte), .nodeId(nodeId), .pllSettings(pllSettings),
  .tileReset(tileReset));
